// file: verilog/ufh_defines.vh
// Purpose: constants for the usage and hard fault status block
// Assumes: word register port, byte addresses chosen locally
// Notes: definitions only
`ifndef UFH_DEFINES_VH
`define UFH_DEFINES_VH

`define UFH_ADDR_W 4
`define UFH_ADDR_USAGE 4'h0
`define UFH_ADDR_HARD 4'h4
`define UFH_ADDR_CTRL 4'h8

`define UFH_BIT_UNDEF 0
`define UFH_BIT_STATE 1
`define UFH_BIT_RETPC 2
`define UFH_BIT_NO_COPROC_FLAG 3
`define UFH_BIT_ALIGN 8
`define UFH_BIT_DIV0 9
`define UFH_USAGE_W 16
`define UFH_USAGE_MASK 16'h030F

`define UFH_BIT_VECT 1
`define UFH_BIT_FORCED 30
`define UFH_BIT_DEBUG 31
`define UFH_HARD_MASK 32'hC0000002

`define UFH_CTRL_ALIGN 3
`define UFH_CTRL_DIV0 4
`define UFH_CTRL_MASK 32'h00000018

`define UFH_ZERO32 32'h00000000
`define UFH_ZERO16 16'h0000
`define UFH_PC_ZERO 32'h00000000

`endif

// file: verilog/ufh_sticky.v
// Purpose: one sticky status flag, set by hardware, cleared by write one
// Assumes: set and clear from logic on the same clock
// Notes: set wins over a clear in the same cycle
`timescale 1ns/10ps

module ufh_sticky (
    input wire clk,
    input wire arst_n,
    input wire set,
    input wire clr,
    output reg flag
);

always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        flag <= 1'b0;
    end else if (set) begin
        flag <= 1'b1;
    end else if (clr) begin
        flag <= 1'b0;
    end
end

endmodule

// file: verilog/ufh_fault_status.v
// Purpose: usage and hard fault status flags with exception requests
// Assumes: fault events are one-cycle pulses from the pipeline, same clock
// Notes: registers on a plain port, read data one cycle after the strobe
//
// How it works
// - zero divisor divide with trap enabled sets bit 9 of usage status
// - divide fault stacks the address of the divide instruction
// - divide faults raised only with divide trap enable set
// - unaligned access with trap enabled sets bit 8
// - unaligned multi or doubleword accesses always fault
// - any coprocessor access sets bit 3
// - illegal exception return load into the pc sets bit 2
// - bad return fault stacks the pc of the offending load
// - illegal execution status use sets bit 1, stacking its pc
// - undecodable instruction suppresses the bad state flag
// - undecodable instruction sets bit 0, stacking its pc
// - usage flags sticky, cleared by writing one or reset
// - hard status reads normally, writing one clears a bit
// - hard flags sticky until write one or reset
// - escalation of a configurable fault sets bit 30
// - vector fault stacks the pc of the preempted instruction
`timescale 1ns/10ps
`include "ufh_defines.vh"

module ufh_fault_status (
    input wire CLK,
    input wire ARST_N,
    input wire [`UFH_ADDR_W-1:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [31:0] RDATA,
    input wire [31:0] INSTR_PC,
    input wire [31:0] PREEMPT_PC,
    input wire DIV_EXEC,
    input wire DIV_ZERO,
    input wire MEM_ACCESS,
    input wire MEM_UNALIGNED,
    input wire MEM_MULTI_OR_DOUBLE,
    input wire COPROC_ACCESS,
    input wire BAD_RETURN_LOAD,
    input wire BAD_STATE_USE,
    input wire UNDECODABLE,
    input wire USAGE_ESCALATE,
    input wire OTHER_ESCALATE,
    input wire VECTOR_FETCH_FAULT,
    input wire DEBUG_EVENT,
    output reg USAGE_REQ,
    output reg HARD_REQ,
    output reg [31:0] STACKED_PC,
    output reg STACKED_PC_VALID
);

////////////////////////////////////////////////////////////////////////
// control register: trap enables

reg zero_divisor_trap_enable;
reg misaligned_trap_enable;
wire wr_usage;
wire wr_hard;
wire wr_ctrl;

assign wr_usage = WR && (ADDR == `UFH_ADDR_USAGE);
assign wr_hard = WR && (ADDR == `UFH_ADDR_HARD);
assign wr_ctrl = WR && (ADDR == `UFH_ADDR_CTRL);

always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
        zero_divisor_trap_enable <= 1'b0;
        misaligned_trap_enable <= 1'b0;
    end else if (wr_ctrl) begin
        zero_divisor_trap_enable <= WDATA[`UFH_CTRL_DIV0];
        misaligned_trap_enable <= WDATA[`UFH_CTRL_ALIGN];
    end
end

////////////////////////////////////////////////////////////////////////
// fault detection

wire ev_div0;
wire ev_align;
wire ev_no_coproc_flag;
wire ev_retpc;
wire ev_state;
wire ev_undef;
wire any_usage;

assign ev_div0 = DIV_EXEC && DIV_ZERO && zero_divisor_trap_enable;
assign ev_align = MEM_ACCESS && MEM_UNALIGNED &&
    (misaligned_trap_enable || MEM_MULTI_OR_DOUBLE);
assign ev_no_coproc_flag = COPROC_ACCESS;
assign ev_retpc = BAD_RETURN_LOAD;
assign ev_state = BAD_STATE_USE && !UNDECODABLE;
assign ev_undef = UNDECODABLE;
assign any_usage = ev_div0 | ev_align | ev_no_coproc_flag | ev_retpc | ev_state | ev_undef;

////////////////////////////////////////////////////////////////////////
// sticky flags

wire zero_divisor_flag;
wire misaligned_flag;
wire no_coproc_flag;
wire bad_return_pc_flag;
wire bad_exec_state_flag;
wire undecodable_op_flag;
wire forced_flag;
wire vector_fetch_fault_flag;
wire debug_reserved_bit;
wire ev_forced;

assign ev_forced = (any_usage && USAGE_ESCALATE) || OTHER_ESCALATE;

ufh_sticky u_div0 (
    .clk(CLK),
    .arst_n(ARST_N),
    .set(ev_div0),
    .clr(wr_usage && WDATA[`UFH_BIT_DIV0]),
    .flag(zero_divisor_flag)
);

ufh_sticky u_align (
    .clk(CLK),
    .arst_n(ARST_N),
    .set(ev_align),
    .clr(wr_usage && WDATA[`UFH_BIT_ALIGN]),
    .flag(misaligned_flag)
);

ufh_sticky u_no_coproc_flag (
    .clk(CLK),
    .arst_n(ARST_N),
    .set(ev_no_coproc_flag),
    .clr(wr_usage && WDATA[`UFH_BIT_NO_COPROC_FLAG]),
    .flag(no_coproc_flag)
);

ufh_sticky u_retpc (
    .clk(CLK),
    .arst_n(ARST_N),
    .set(ev_retpc),
    .clr(wr_usage && WDATA[`UFH_BIT_RETPC]),
    .flag(bad_return_pc_flag)
);

ufh_sticky u_state (
    .clk(CLK),
    .arst_n(ARST_N),
    .set(ev_state),
    .clr(wr_usage && WDATA[`UFH_BIT_STATE]),
    .flag(bad_exec_state_flag)
);

ufh_sticky u_undef (
    .clk(CLK),
    .arst_n(ARST_N),
    .set(ev_undef),
    .clr(wr_usage && WDATA[`UFH_BIT_UNDEF]),
    .flag(undecodable_op_flag)
);

ufh_sticky u_forced (
    .clk(CLK),
    .arst_n(ARST_N),
    .set(ev_forced),
    .clr(wr_hard && WDATA[`UFH_BIT_FORCED]),
    .flag(forced_flag)
);

ufh_sticky u_vect (
    .clk(CLK),
    .arst_n(ARST_N),
    .set(VECTOR_FETCH_FAULT),
    .clr(wr_hard && WDATA[`UFH_BIT_VECT]),
    .flag(vector_fetch_fault_flag)
);

ufh_sticky u_debug (
    .clk(CLK),
    .arst_n(ARST_N),
    .set(DEBUG_EVENT),
    .clr(wr_hard && WDATA[`UFH_BIT_DEBUG]),
    .flag(debug_reserved_bit)
);

////////////////////////////////////////////////////////////////////////
// exception requests and stacked return pc

always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
        USAGE_REQ <= 1'b0;
        HARD_REQ <= 1'b0;
        STACKED_PC <= `UFH_PC_ZERO;
        STACKED_PC_VALID <= 1'b0;
    end else begin
        USAGE_REQ <= any_usage && !USAGE_ESCALATE;
        HARD_REQ <= ev_forced || VECTOR_FETCH_FAULT;
        STACKED_PC_VALID <= any_usage || VECTOR_FETCH_FAULT;
        if (VECTOR_FETCH_FAULT) begin
            STACKED_PC <= PREEMPT_PC;
        end else if (any_usage) begin
            STACKED_PC <= INSTR_PC;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// register read port

reg [31:0] next_rdata;

always @* begin
    next_rdata = `UFH_ZERO32;
    if (ADDR == `UFH_ADDR_USAGE) begin
        next_rdata[`UFH_BIT_DIV0] = zero_divisor_flag;
        next_rdata[`UFH_BIT_ALIGN] = misaligned_flag;
        next_rdata[`UFH_BIT_NO_COPROC_FLAG] = no_coproc_flag;
        next_rdata[`UFH_BIT_RETPC] = bad_return_pc_flag;
        next_rdata[`UFH_BIT_STATE] = bad_exec_state_flag;
        next_rdata[`UFH_BIT_UNDEF] = undecodable_op_flag;
    end else if (ADDR == `UFH_ADDR_HARD) begin
        next_rdata[`UFH_BIT_DEBUG] = debug_reserved_bit;
        next_rdata[`UFH_BIT_FORCED] = forced_flag;
        next_rdata[`UFH_BIT_VECT] = vector_fetch_fault_flag;
    end else if (ADDR == `UFH_ADDR_CTRL) begin
        next_rdata[`UFH_CTRL_DIV0] = zero_divisor_trap_enable;
        next_rdata[`UFH_CTRL_ALIGN] = misaligned_trap_enable;
    end
end

always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
        RDATA <= `UFH_ZERO32;
    end else if (RD) begin
        RDATA <= next_rdata;
    end else begin
        RDATA <= `UFH_ZERO32;
    end
end

endmodule

// file: bench/ufh_fault_sva.sv
// Purpose: port checker for ufh_fault_status
// Assumes: one clock, async active-low reset
// Notes: bound below
`timescale 1ns/10ps
`include "ufh_defines.vh"

module ufh_fault_sva (
    input wire CLK,
    input wire ARST_N,
    input wire [`UFH_ADDR_W-1:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [31:0] RDATA,
    input wire [31:0] INSTR_PC,
    input wire COPROC_ACCESS,
    input wire UNDECODABLE,
    input wire USAGE_ESCALATE,
    input wire VECTOR_FETCH_FAULT,
    input wire USAGE_REQ,
    input wire HARD_REQ,
    input wire [31:0] STACKED_PC,
    input wire STACKED_PC_VALID
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("rdata not idle");
    a_usage_rsvd: assert property ($past(RD) && $past(ADDR) == `UFH_ADDR_USAGE
        |-> (RDATA & 32'hFFFFFCF0) == 32'h0) else $error("usage reserved bits set");
    a_hard_rsvd: assert property ($past(RD) && $past(ADDR) == `UFH_ADDR_HARD
        |-> (RDATA & 32'h3FFFFFFD) == 32'h0) else $error("hard reserved bits set");
    a_coproc_req: assert property (COPROC_ACCESS && !USAGE_ESCALATE |=> USAGE_REQ)
        else $error("no usage request");
    a_escal_hard: assert property (COPROC_ACCESS && USAGE_ESCALATE
        |=> HARD_REQ && !USAGE_REQ) else $error("escalation request wrong");
    a_undef_pc: assert property (UNDECODABLE && !VECTOR_FETCH_FAULT
        |=> STACKED_PC_VALID && STACKED_PC == $past(INSTR_PC)) else $error("stacked pc wrong");
    a_pc_hold: assert property (!STACKED_PC_VALID |-> $stable(STACKED_PC))
        else $error("stacked pc moved");
    a_undef_read: assert property (UNDECODABLE ##1 !WR ##1 (RD && ADDR == 4'h0)
        |=> RDATA[`UFH_BIT_UNDEF]) else $error("flag not held");
    a_w1c_clear: assert property (WR && !UNDECODABLE && ADDR == 4'h0 && WDATA[0]
        ##1 !UNDECODABLE ##1 (RD && ADDR == 4'h0) |=> !RDATA[0]) else $error("flag not cleared");
endmodule

bind ufh_fault_status ufh_fault_sva u_sva (.CLK, .ARST_N, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .INSTR_PC, .COPROC_ACCESS, .UNDECODABLE, .USAGE_ESCALATE, .VECTOR_FETCH_FAULT,
    .USAGE_REQ, .HARD_REQ, .STACKED_PC, .STACKED_PC_VALID);

// file: bench/ufh_pipe_model.sv
// Purpose: pipeline model raising fault pulses
// Assumes: same clock as the block
// Notes: pc lines scrambled between events
`timescale 1ns/10ps

module ufh_pipe_model (
    input wire clk,
    output reg [12:0] ev,
    output reg [31:0] pc,
    output reg [31:0] pre_pc
);
    initial begin
        ev = 13'h0000;
        pc = 32'h00000000;
        pre_pc = 32'hFFFFFFFF;
    end
    task fire(input [12:0] e, input [31:0] p);
        @(posedge clk);
        ev <= e;
        pc <= p;
        pre_pc <= p + 32'h4;
        @(posedge clk);
        ev <= 13'h0000;
        pc <= ~p;
        pre_pc <= ~p;
    endtask
endmodule

// file: bench/tb_top.sv
// Purpose: self-checking bench for ufh_fault_status
// Assumes: plain register port, pipeline model
// Notes: none
`timescale 1ns/10ps
`include "ufh_defines.vh"

module tb_top;
    localparam [129:0] EVS = {13'h0030, 13'h0010, 13'h0020, 13'h0040, 13'h0080,
        13'h0700, 13'h0600, 13'h0600, 13'h1800, 13'h1800};
    localparam [49:0] CTL = {35'h0, 5'h08, 5'h00, 5'h10};
    localparam [99:0] EXB = {10'h001, 10'h001, 10'h002, 10'h004, 10'h008,
        10'h100, 10'h000, 10'h100, 10'h000, 10'h200};
    reg clk = 1'b0;
    reg arst_n = 1'b0;
    reg [3:0] addr = 4'h0;
    reg [31:0] wdata = 32'h0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    wire [31:0] rdata, pc, pre_pc, stk_pc;
    wire [12:0] ev;
    wire usage_req, hard_req, stk_valid;
    integer n_fail = 0;
    integer cmp_count = 0;
    integer cyc = 0;
    always #5 clk = ~clk;
    ufh_pipe_model u_pipe (.clk(clk), .ev(ev), .pc(pc), .pre_pc(pre_pc));
    ufh_fault_status DUT (.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .INSTR_PC(pc), .PREEMPT_PC(pre_pc), .DIV_EXEC(ev[12]),
        .DIV_ZERO(ev[11]), .MEM_ACCESS(ev[10]), .MEM_UNALIGNED(ev[9]),
        .MEM_MULTI_OR_DOUBLE(ev[8]), .COPROC_ACCESS(ev[7]), .BAD_RETURN_LOAD(ev[6]),
        .BAD_STATE_USE(ev[5]), .UNDECODABLE(ev[4]), .USAGE_ESCALATE(ev[3]),
        .OTHER_ESCALATE(ev[2]), .VECTOR_FETCH_FAULT(ev[1]), .DEBUG_EVENT(ev[0]),
        .USAGE_REQ(usage_req), .HARD_REQ(hard_req), .STACKED_PC(stk_pc),
        .STACKED_PC_VALID(stk_valid));
    ////////////////////////////////////////////////////////////////////////////////
    task final_report;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr_reg(input [3:0] a, input [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_chk(input [3:0] a, input [31:0] e, input string nm);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_regs;
        rd_chk(`UFH_ADDR_USAGE, 32'h0, "usage reset");
        rd_chk(`UFH_ADDR_HARD, 32'h0, "hard reset");
        rd_chk(4'hC, 32'h0, "unmapped");
        wr_reg(`UFH_ADDR_CTRL, 32'hFFFFFFFF);
        rd_chk(`UFH_ADDR_CTRL, `UFH_CTRL_MASK, "ctrl reserved");
        $display("t_regs end");
    endtask
    task t_usage;
        integer i;
        reg [31:0] x;
        for (i = 0; i < 10; i = i + 1) begin
            x = {22'h0, EXB[i*10 +: 10]};
            wr_reg(`UFH_ADDR_CTRL, {27'h0, CTL[i*5 +: 5]});
            u_pipe.fire(EVS[i*13 +: 13], 32'h1000 + i * 4);
            #1;
            chk("usage_req", {31'h0, x != 32'h0}, {31'h0, usage_req});
            chk("stacked valid", {31'h0, x != 32'h0}, {31'h0, stk_valid});
            if (x != 32'h0) chk("stacked pc", 32'h1000 + i * 4, stk_pc);
            rd_chk(`UFH_ADDR_USAGE, x, "usage flag");
            wr_reg(`UFH_ADDR_USAGE, 32'h0);
            rd_chk(`UFH_ADDR_USAGE, x, "usage sticky");
            wr_reg(`UFH_ADDR_USAGE, 32'hFFFF);
            rd_chk(`UFH_ADDR_USAGE, 32'h0, "usage w1c");
        end
        $display("t_usage end");
    endtask
    task t_hard;
        u_pipe.fire(13'h0088, 32'h2000);
        #1;
        chk("hard_req", 32'h1, {31'h0, hard_req});
        chk("usage_req", 32'h0, {31'h0, usage_req});
        u_pipe.fire(13'h0002, 32'h3000);
        #1;
        chk("vector pc", 32'h3004, stk_pc);
        chk("vector valid", 32'h1, {31'h0, stk_valid});
        u_pipe.fire(13'h0001, 32'h0);
        rd_chk(`UFH_ADDR_USAGE, 32'h8, "escalated flag");
        rd_chk(`UFH_ADDR_HARD, 32'hC0000002, "hard flags");
        wr_reg(`UFH_ADDR_HARD, 32'h80000002);
        rd_chk(`UFH_ADDR_HARD, 32'h40000000, "hard w1c");
        wr_reg(`UFH_ADDR_HARD, 32'hC0000000);
        rd_chk(`UFH_ADDR_HARD, 32'h0, "hard clear");
        u_pipe.fire(13'h0004, 32'h0);
        rd_chk(`UFH_ADDR_HARD, 32'h40000000, "forced");
        $display("t_hard end");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_fail = n_fail + 1;
            final_report;
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        t_regs;
        t_usage;
        t_hard;
        final_report;
    end
endmodule
